// File: logic/uscf_regs.vh
// Register map, field positions and timing for the serial port.
// Assumes a 100 MHz system clock and byte addressed 32-bit registers.
`ifndef USCF_REGS_VH
`define USCF_REGS_VH
// ********************
// Addresses
// ********************
`define USCF_AW 8
`define USCF_A_STAT 8'h1c
`define USCF_A_CFG0 8'h20
`define USCF_A_CFG1 8'h24
// ********************
// Frame config fields
// ********************
`define USCF_C0_MASK 32'h01ff_c1ff
`define USCF_F_PAR 0
`define USCF_F_PEN 1
`define USCF_F_WL 3:2
`define USCF_F_STOP 5:4
`define USCF_F_SRTS 6
`define USCF_F_SDTR 7
`define USCF_F_BRK 8
`define USCF_F_LOOP 14
`define USCF_F_TXFC 15
`define USCF_F_RXRST 17
`define USCF_F_TXRST 18
`define USCF_F_RXINV 19
`define USCF_F_CTSINV 20
`define USCF_F_DSRINV 21
`define USCF_F_TXINV 22
`define USCF_F_RTSINV 23
`define USCF_F_DTRINV 24
// ********************
// Threshold config fields
// ********************
`define USCF_C1_MASK 32'hffff_7f00
`define USCF_F_TOEN 31
`define USCF_F_TOTHR 30:24
`define USCF_F_RXFC 23
`define USCF_F_RXFTHR 22:16
`define USCF_F_TXETHR 14:8
// ********************
// Timing and sizes
// ********************
`define USCF_CLK_NS 10
`define USCF_BIT_NS 160
`define USCF_HB_CYC (`USCF_BIT_NS / 2 / `USCF_CLK_NS)
`define USCF_BIT_CYC (`USCF_BIT_NS / `USCF_CLK_NS)
`define USCF_BYTE_HB 20
`define USCF_DEPTH 16
`define USCF_PW 4
`define USCF_CFG_RST 32'h0000_0000
`endif

// File: logic/uscf_top.v
// Serial port with frame, flow, inversion and loopback configuration.
// Assumes pins and user strobes are synchronous to clock.
`timescale 1ns/1ps
`include "uscf_regs.vh"

// ********************
// Small flop FIFO
// ********************
module uscf_fifo (
	input wire clock,
	input wire rst,
	input wire clr,
	input wire push,
	input wire [7:0] din,
	input wire pop,
	output wire [7:0] head,
	output wire [7:0] count,
	output wire full,
	output wire empty
);
	reg [7:0] mem_q [0:`USCF_DEPTH-1]; // Storage
	reg [`USCF_PW-1:0] wp_q; // Write index
	reg [`USCF_PW-1:0] rp_q; // Read index
	reg [7:0] cnt_q; // Fill count
	wire do_push;
	wire do_pop;
	assign full = (cnt_q == `USCF_DEPTH);
	assign empty = (cnt_q == 8'h00);
	assign do_push = push && !full && !clr;
	assign do_pop = pop && !empty && !clr;
	assign head = mem_q[rp_q];
	assign count = cnt_q;
	// Pointers; clear holds the FIFO empty while high
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wp_q <= {`USCF_PW{1'b0}};
			rp_q <= {`USCF_PW{1'b0}};
			cnt_q <= 8'h00;
		end
		else if (clr)
		begin
			wp_q <= {`USCF_PW{1'b0}};
			rp_q <= {`USCF_PW{1'b0}};
			cnt_q <= 8'h00;
		end
		else
		begin
			if (do_push)
				wp_q <= wp_q + 1'b1;
			if (do_pop)
				rp_q <= rp_q + 1'b1;
			if (do_push && !do_pop)
				cnt_q <= cnt_q + 8'h01;
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - 8'h01;
		end
	end
	// Data store, no reset needed
	always @(posedge clock)
	begin
		if (do_push)
			mem_q[wp_q] <= din;
	end
endmodule // uscf_fifo

// Contract
// - Stop bits: 1, 1.5 or 2
// - Word length code gives 5 to 8 bits
// - Parity enable adds and checks parity
// - Parity sense: 0 even, 1 odd
// - Time-out only when enabled
// - Time-out threshold in byte times, 0-127
// - Receive FIFO reset empties it
// - Transmit FIFO reset empties it
// - Loopback feeds transmitter into receiver
// - Transmit waits while clear-to-send deasserted
// - Request-to-send follows receive fill level
// - Transmit fill compared with empty threshold
// - Per-pin inversion bits flip line levels
// - Clear-to-send inverted before flow and status
// - Receive data inverted before sampling
// - Transmit fill count readable
// - Receive fill count readable
// - Live line levels readable
// - Software bits drive ready line, and request line while receive flow is off
// - Configuration resets to zero
module uscf_top (
	input wire clock,
	input wire rst,
	input wire [`USCF_AW-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire tx_wr,
	input wire [7:0] tx_wdata,
	output wire tx_ready,
	input wire rx_rd,
	output reg [7:0] rx_rdata,
	output wire rx_avail,
	output wire ser_tx,
	input wire ser_rx,
	input wire clear_send_n,
	input wire set_ready_n,
	output wire request_send_n,
	output wire terminal_ready_n
);
	// ********************
	// Registers
	// ********************
	reg [31:0] cfg0_q; // Frame config
	reg [31:0] cfg1_q; // Threshold config
	reg perr_q; // Sticky parity error
	reg tout_q; // Sticky time-out
	wire [31:0] stat; // Status word
	wire [7:0] txcnt;
	wire [7:0] rxcnt;
	wire [7:0] txhead;
	wire [7:0] rxhead;
	wire txfull;
	wire txempty;
	wire rxfull;
	wire rxempty;
	wire stat_rd;
	assign stat_rd = reg_rd && (reg_addr == `USCF_A_STAT);

	// Config writes; all fields start at zero
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cfg0_q <= `USCF_CFG_RST;
			cfg1_q <= `USCF_CFG_RST;
		end
		else if (reg_wr)
		begin
			// Reserved bit is stored as written by software
			if (reg_addr == `USCF_A_CFG0)
				cfg0_q <= reg_wdata & `USCF_C0_MASK;
			if (reg_addr == `USCF_A_CFG1)
				cfg1_q <= reg_wdata & `USCF_C1_MASK;
		end
	end

	// Field decode
	wire [3:0] nbits; // Data bits per char
	wire pbit; // One when parity is used
	wire [3:0] nsamp; // Data plus parity bits
	assign nbits = {2'b00, cfg0_q[`USCF_F_WL]} + 4'h5;
	assign pbit = cfg0_q[`USCF_F_PEN];
	assign nsamp = nbits + {3'b000, pbit};

	// ********************
	// FIFOs
	// ********************
	wire tx_pop;
	wire rx_push;
	wire [7:0] rx_word;
	assign tx_ready = !txfull && !cfg0_q[`USCF_F_TXRST];
	assign rx_avail = !rxempty;

	uscf_fifo u_txf (
		.clock(clock),
		.rst(rst),
		.clr(cfg0_q[`USCF_F_TXRST]),
		.push(tx_wr),
		.din(tx_wdata),
		.pop(tx_pop),
		.head(txhead),
		.count(txcnt),
		.full(txfull),
		.empty(txempty)
	);

	uscf_fifo u_rxf (
		.clock(clock),
		.rst(rst),
		.clr(cfg0_q[`USCF_F_RXRST]),
		.push(rx_push),
		.din(rx_word),
		.pop(rx_rd),
		.head(rxhead),
		.count(rxcnt),
		.full(rxfull),
		.empty(rxempty)
	);

	// Receive data register, valid after the pop
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			rx_rdata <= 8'h00;
		else if (rx_rd && !rxempty)
			rx_rdata <= rxhead;
	end

	// ********************
	// Pin levels
	// ********************
	wire cts_act; // Clear-to-send, asserted high
	wire dsr_act; // Data-set-ready, asserted high
	wire rts_act;
	wire dtr_act;
	wire tx_line; // Internal transmit level
	wire rx_line; // Internal receive level
	assign cts_act = ~clear_send_n ^ cfg0_q[`USCF_F_CTSINV];
	assign dsr_act = ~set_ready_n ^ cfg0_q[`USCF_F_DSRINV];
	// Flow control owns the line while enabled
	assign rts_act = cfg1_q[`USCF_F_RXFC] ?
		(rxcnt < {1'b0, cfg1_q[`USCF_F_RXFTHR]}) :
		cfg0_q[`USCF_F_SRTS];
	assign dtr_act = cfg0_q[`USCF_F_SDTR];
	assign request_send_n = ~rts_act ^ cfg0_q[`USCF_F_RTSINV];
	assign terminal_ready_n = ~dtr_act ^ cfg0_q[`USCF_F_DTRINV];
	// Break wins over data; inversion is applied last
	assign ser_tx = (tx_line & ~cfg0_q[`USCF_F_BRK])
		^ cfg0_q[`USCF_F_TXINV];
	// Loopback bypasses both pin inversions
	assign rx_line = cfg0_q[`USCF_F_LOOP] ? tx_line :
		(ser_rx ^ cfg0_q[`USCF_F_RXINV]);

	// ********************
	// Transmitter
	// ********************
	reg [10:0] tsh_q; // Frame shifter, LSB on line
	reg [4:0] tleft_q; // Half bits remaining
	reg tph_q; // Half-bit phase
	reg [7:0] thc_q; // Cycles within half bit
	wire tx_go;
	wire thtick;
	wire [7:0] tmask; // Data mask for word length
	wire [7:0] tdat;
	wire tpar;
	wire [10:0] tbody;
	reg [4:0] stop_hb; // Stop length in half bits

	assign tmask = ~(8'hff << nbits);
	assign tdat = txhead & tmask;
	// Even parity makes the ones count even, odd makes it odd
	assign tpar = ^tdat ^ cfg0_q[`USCF_F_PAR];
	// Data, then parity slot, then ones; parity slot only sent if enabled
	assign tbody = ({3'b111, tdat} & ~(11'h7ff << nbits)) |
		({10'h3ff, tpar | ~pbit} << nbits);
	// Hold new characters while the far end is not clear
	assign tx_go = (tleft_q == 5'h00) && !txempty &&
		!cfg0_q[`USCF_F_TXRST] &&
		(!cfg0_q[`USCF_F_TXFC] || cts_act);
	assign tx_pop = tx_go;
	assign thtick = (thc_q == `USCF_HB_CYC - 1);
	assign tx_line = (tleft_q == 5'h00) ? 1'b1 : tsh_q[0];

	// Stop length; code 0 is taken as one bit
	always @*
	begin
		case (cfg0_q[`USCF_F_STOP])
			2'b10: stop_hb = 5'h03;
			2'b11: stop_hb = 5'h04;
			default: stop_hb = 5'h02;
		endcase
	end

	// Shift out one frame, half a bit per tick
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tsh_q <= 11'h7ff;
			tleft_q <= 5'h00;
			tph_q <= 1'b0;
			thc_q <= 8'h00;
		end
		else if (tx_go)
		begin
			tsh_q <= {tbody[9:0], 1'b0};
			tleft_q <= {nsamp, 1'b0} + 5'h02 + stop_hb;
			tph_q <= 1'b0;
			thc_q <= 8'h00;
		end
		else if (tleft_q != 5'h00)
		begin
			thc_q <= thtick ? 8'h00 : thc_q + 8'h01;
			if (thtick)
			begin
				tleft_q <= tleft_q - 5'h01;
				tph_q <= ~tph_q;
				// Ones shift in so the stop tail idles high
				if (tph_q)
					tsh_q <= {1'b1, tsh_q[10:1]};
			end
		end
	end

	// ********************
	// Receiver
	// ********************
	reg rbusy_q; // Frame in progress
	reg rfirst_q; // Next sample is start bit
	reg [3:0] rleft_q; // Samples left incl. stop
	reg [8:0] rsh_q; // Collected bits, MSB first in
	reg [7:0] rhc_q; // Cycles to next sample
	reg rlast_q; // Previous line level
	// Sample-spacing reloads, sized to the 8-bit cycle counter
	localparam [7:0] HB_LAST = `USCF_HB_CYC - 1;
	localparam [7:0] BIT_LAST = `USCF_BIT_CYC - 1;
	wire rsamp;
	wire [8:0] ralign; // Bits moved to LSB
	assign rsamp = rbusy_q && (rhc_q == 8'h00);
	assign ralign = rsh_q >> (4'h9 - nsamp);
	assign rx_word = ralign[7:0] & tmask;
	assign rx_push = rsamp && !rfirst_q && (rleft_q == 4'h1) && rx_line;

	// Start on a falling edge, sample at bit centres
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rbusy_q <= 1'b0;
			rfirst_q <= 1'b0;
			rleft_q <= 4'h0;
			rsh_q <= 9'h000;
			rhc_q <= 8'h00;
			rlast_q <= 1'b1;
			perr_q <= 1'b0;
		end
		else
		begin
			rlast_q <= rx_line;
			// Clear on status read; a new error in that cycle wins
			if (stat_rd)
				perr_q <= 1'b0;
			if (!rbusy_q)
			begin
				if (rlast_q && !rx_line)
				begin
					rbusy_q <= 1'b1;
					rfirst_q <= 1'b1;
					rleft_q <= nsamp + 4'h1;
					rhc_q <= HB_LAST;
				end
			end
			else if (rsamp)
			begin
				rhc_q <= BIT_LAST;
				rfirst_q <= 1'b0;
				if (rfirst_q)
				begin
					// Glitch shorter than half a bit: give up
					if (rx_line)
						rbusy_q <= 1'b0;
				end
				else if (rleft_q == 4'h1)
				begin
					rbusy_q <= 1'b0;
					// Ones count check over data and parity
					if (pbit && (^ralign ^ cfg0_q[`USCF_F_PAR]))
						perr_q <= 1'b1;
				end
				else
				begin
					rsh_q <= {rx_line, rsh_q[8:1]};
					rleft_q <= rleft_q - 4'h1;
				end
			end
			else
				rhc_q <= rhc_q - 8'h01;
		end
	end

	// ********************
	// Receive time-out
	// ********************
	reg [7:0] tbc_q; // Half bits of idle
	reg [7:0] tby_q; // Byte times of idle
	reg [7:0] tcy_q; // Cycles within half bit
	wire tidle;
	assign tidle = !rbusy_q && !rxempty;

	// Count idle byte times while data waits
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tbc_q <= 8'h00;
			tby_q <= 8'h00;
			tcy_q <= 8'h00;
			tout_q <= 1'b0;
		end
		else
		begin
			if (stat_rd)
				tout_q <= 1'b0;
			if (!tidle || !cfg1_q[`USCF_F_TOEN])
			begin
				tbc_q <= 8'h00;
				tby_q <= 8'h00;
				tcy_q <= 8'h00;
			end
			else
			begin
				tcy_q <= (tcy_q == `USCF_HB_CYC - 1) ? 8'h00 :
					tcy_q + 8'h01;
				if (tcy_q == `USCF_HB_CYC - 1)
				begin
					if (tbc_q == `USCF_BYTE_HB - 1)
					begin
						tbc_q <= 8'h00;
						// Saturate so the flag fires once
						if (tby_q[7] == 1'b0)
							tby_q <= tby_q + 8'h01;
					end
					else
						tbc_q <= tbc_q + 8'h01;
				end
				// Threshold reached; set beats the read clear
				if (tby_q == {1'b0, cfg1_q[`USCF_F_TOTHR]})
					tout_q <= 1'b1;
			end
		end
	end

	// ********************
	// Status and readback
	// ********************
	assign stat = {tout_q, rts_act, dtr_act, 5'h00,
		txcnt,
		rx_line, cts_act, dsr_act,
		3'h0,
		(txcnt < {1'b0, cfg1_q[`USCF_F_TXETHR]}),
		perr_q,
		rxcnt};

	// Read data stands one cycle after the strobe
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`USCF_A_STAT: reg_rdata <= stat;
				`USCF_A_CFG0: reg_rdata <= cfg0_q;
				`USCF_A_CFG1: reg_rdata <= cfg1_q;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end
endmodule // uscf_top

// File: tb/uscf_chk_asserts.sv
// Pin-level checker for the serial port top.
// Assumes registers change only through reg_wr.
`timescale 1ns/1ps
`include "uscf_regs.vh"
module uscf_chk (
	input wire clock,
	input wire rst,
	input wire [`USCF_AW-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire tx_ready,
	input wire rx_avail,
	input wire ser_tx,
	input wire request_send_n,
	input wire terminal_ready_n
);
	reg [31:0] c0_q; // Shadow of frame config
	reg [31:0] c1_q; // Shadow of threshold config
	// Shadows load on the same edge as the design's copies
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			c0_q <= 32'h0000_0000;
			c1_q <= 32'h0000_0000;
		end
		else if (reg_wr && reg_addr == `USCF_A_CFG0)
			c0_q <= reg_wdata & `USCF_C0_MASK;
		else if (reg_wr && reg_addr == `USCF_A_CFG1)
			c1_q <= reg_wdata & `USCF_C1_MASK;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_cfg0_back: assert property (
		reg_rd && reg_addr == `USCF_A_CFG0 |=> reg_rdata == $past(c0_q))
		else $error("frame config readback wrong");
	chk_cfg1_back: assert property (
		reg_rd && reg_addr == `USCF_A_CFG1 |=> reg_rdata == $past(c1_q))
		else $error("threshold config readback wrong");
	chk_dtr_level: assert property (
		terminal_ready_n == (c0_q[7] == c0_q[24]))
		else $error("ready line level wrong");
	chk_rts_soft: assert property (
		!c1_q[23] |-> request_send_n == (c0_q[6] == c0_q[23]))
		else $error("request line level wrong");
	chk_break_space: assert property (
		c0_q[8] |-> ser_tx == c0_q[22])
		else $error("break not at space");
	chk_txrst_hold: assert property (
		c0_q[18] |-> !tx_ready)
		else $error("transmit queue open in reset");
	chk_rxrst_empty: assert property (
		c0_q[17] [*2] |-> !rx_avail)
		else $error("receive queue not empty in reset");
	chk_txcnt_zero: assert property (
		$past(c0_q[18]) && c0_q[18] && reg_rd && reg_addr == `USCF_A_STAT
		|=> reg_rdata[23:16] == 8'h00)
		else $error("transmit count not cleared");
endmodule // uscf_chk
bind uscf_top uscf_chk i_uscf_chk (.clock(clock), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ready(tx_ready),
	.rx_avail(rx_avail), .ser_tx(ser_tx), .request_send_n(request_send_n),
	.terminal_ready_n(terminal_ready_n));

// File: tb/uscf_remote.sv
// Remote serial device: sends frames and samples the transmit line.
// Assumes 16 clocks per bit, as the design is set.
`timescale 1ns/1ps
module uscf_remote (
	input wire clock,
	input wire ser_tx,
	output wire ser_rx,
	output reg clear_send_n,
	output reg set_ready_n
);
	reg line_q = 1'b1; // Level before polarity, idles at mark
	reg inv = 1'b0; // Flips the line for inverted links
	integer cyc = 0; // Free count that stamps frame starts
	integer t_start = 0;
	initial clear_send_n = 1'b1;
	initial set_ready_n = 1'b1;
	always @(posedge clock) cyc <= cyc + 1;
	assign ser_rx = line_q ^ inv;
	// Start, n data bits low first, one stop bit
	task send(input [7:0] d, input integer n);
		integer i;
		begin
			for (i = -1; i <= n; i = i + 1)
			begin
				line_q <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
				repeat (16) @(posedge clock);
			end
		end
	endtask
	// Bounded hunt for a start, then n samples at bit centres
	task grab(input integer n, output [11:0] b);
		integer i;
		begin
			b = 12'h000;
			i = 0;
			while (ser_tx !== 1'b0 && i < 3000)
			begin
				@(posedge clock);
				#1 i = i + 1;
			end
			t_start = cyc;
			repeat (8) @(posedge clock);
			for (i = 0; i < n; i = i + 1)
			begin
				#1 b[i] = ser_tx;
				repeat (16) @(posedge clock);
			end
		end
	endtask
endmodule // uscf_remote

// File: tb/uscf_top_tb_top.sv
// Bench for the serial port: registers, frames, flow and resets.
// Assumes the remote model owns the line pins.
`timescale 1ns/1ps
`include "uscf_regs.vh"
module uscf_top_tb_top;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0000_0000;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg tx_wr = 1'b0;
	reg [7:0] tx_wdata = 8'h00;
	reg rx_rd = 1'b0;
	wire [31:0] reg_rdata;
	wire [7:0] rx_rdata;
	wire tx_ready, rx_avail, ser_tx, ser_rx, cts_n, dsr_n, rts_n, dtr_n;
	integer n_errors = 0;
	integer total_checks = 0;
	integer cyc = 0;
	integer i, g, e, nb, pb;
	reg [31:0] v;
	reg [11:0] b;
	reg [7:0] d, c;
	always #5 clock = ~clock;
	uscf_top i_uscf_top (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
		.tx_ready(tx_ready), .rx_rd(rx_rd), .rx_rdata(rx_rdata),
		.rx_avail(rx_avail), .ser_tx(ser_tx), .ser_rx(ser_rx),
		.clear_send_n(cts_n), .set_ready_n(dsr_n),
		.request_send_n(rts_n), .terminal_ready_n(dtr_n));
	uscf_remote i_uscf_remote (.clock(clock), .ser_tx(ser_tx),
		.ser_rx(ser_rx), .clear_send_n(cts_n), .set_ready_n(dsr_n));
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp)
			begin
				n_errors = n_errors + 1;
				$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask
	// Bus cycles start just after an edge and end just after one
	task wr(input [7:0] a, input [31:0] w);
		begin
			reg_addr <= a;
			reg_wdata <= w;
			reg_wr <= 1'b1;
			@(posedge clock);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clock);
			reg_rd <= 1'b0;
			@(posedge clock);
			v = reg_rdata;
		end
	endtask
	task push(input [7:0] w);
		begin
			tx_wdata <= w;
			tx_wr <= 1'b1;
			@(posedge clock);
			tx_wr <= 1'b0;
		end
	endtask
	task pop;
		begin
			rx_rd <= 1'b1;
			@(posedge clock);
			rx_rd <= 1'b0;
			@(posedge clock);
			d = rx_rdata;
		end
	endtask
	task tally_and_finish;
		begin
			if (n_errors == 0 && total_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Hang guard, far above the few thousand cycles needed
	always @(posedge clock)
	begin
		cyc = cyc + 1;
		if (cyc == 30000)
		begin
			n_errors = n_errors + 1;
			tally_and_finish;
		end
	end
	// ********************
	// Main sequence
	// ********************
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(`USCF_A_CFG0); chk(v, 32'h0000_0000);
		rd(`USCF_A_CFG1); chk(v, 32'h0000_0000);
		rd(8'h28); chk(v, 32'h0000_0000);
		// Reserved bit 16 written low; it reads back as written
		wr(`USCF_A_CFG0, 32'hfffe_ffff);
		rd(`USCF_A_CFG0); chk(v, `USCF_C0_MASK & 32'hfffe_ffff);
		wr(`USCF_A_CFG1, 32'hffff_ffff);
		rd(`USCF_A_CFG1); chk(v, `USCF_C1_MASK);
		wr(`USCF_A_CFG1, 32'h0000_0000);
		// Format table {stop, length, parity on, odd}
		for (i = 0; i < 4; i = i + 1)
		begin
			c = (i == 0) ? 8'h13 : (i == 1) ? 8'h26 : (i == 2) ? 8'h38 : 8'h1f;
			wr(`USCF_A_CFG0, {24'h0, c});
			nb = 5 + c[3:2];
			pb = c[1];
			push(8'hb6 ^ i[7:0]);
			push(8'h4d);
			i_uscf_remote.grab(1 + nb + pb, b);
			g = i_uscf_remote.t_start;
			d = (8'hb6 ^ i[7:0]) & ((8'h01 << nb) - 8'h01);
			e = ({24'h0, d} << 1) | (((^d ^ c[0]) & pb) << (nb + 1));
			chk({20'h0, b}, e);
			i_uscf_remote.grab(1, b);
			g = i_uscf_remote.t_start - g;
			e = 16 * (1 + nb + pb) + 8 * (c[5:4] + 1);
			chk({31'h0, g >= e - 2 && g <= e + 2}, 1);
			// Let the second frame end before the format changes
			repeat (200) @(posedge clock);
		end
		// Loopback, then time-out off and on with data held
		wr(`USCF_A_CFG0, 32'h0000_400c);
		push(8'ha5);
		push(8'h5a);
		repeat (400) @(posedge clock);
		rd(`USCF_A_STAT); chk(v[7:0], 2);
		pop; chk(d, 8'ha5);
		rd(`USCF_A_STAT);
		repeat (400) @(posedge clock);
		rd(`USCF_A_STAT); chk(v[31], 0);
		wr(`USCF_A_CFG1, 32'h8100_0000);
		repeat (400) @(posedge clock);
		rd(`USCF_A_STAT); chk(v[31], 1);
		wr(`USCF_A_CFG0, 32'h0002_400c);
		@(posedge clock);
		rd(`USCF_A_STAT); chk(v[7:0], 0);
		// Inverted receive line, receive flow, then a parity fault
		i_uscf_remote.inv <= 1'b1;
		wr(`USCF_A_CFG0, 32'h0008_000c);
		wr(`USCF_A_CFG1, 32'h0081_0000);
		repeat (20) @(posedge clock);
		chk(rts_n, 0);
		i_uscf_remote.send(8'h3c, 8);
		repeat (20) @(posedge clock);
		chk(rts_n, 1);
		pop; chk(d, 8'h3c);
		rd(`USCF_A_STAT); chk(v[15:13], 4);
		chk(v[30], 1);
		// Seven bits, odd parity; the sent parity bit is wrong
		wr(`USCF_A_CFG0, 32'h0008_000b);
		i_uscf_remote.send(8'h81, 8);
		repeat (20) @(posedge clock);
		rd(`USCF_A_STAT); chk(v[8], 1);
		pop; chk(d, 8'h01);
		// Flow hold with inverted clear-to-send
		i_uscf_remote.inv <= 1'b0;
		i_uscf_remote.clear_send_n <= 1'b0;
		wr(`USCF_A_CFG0, 32'h0010_800c);
		wr(`USCF_A_CFG1, 32'h0000_0400);
		push(8'h11);
		push(8'h22);
		push(8'h33);
		repeat (100) @(posedge clock);
		chk(ser_tx, 1);
		rd(`USCF_A_STAT); chk(v[23:16], 3);
		chk(v[9], 1);
		wr(`USCF_A_CFG0, 32'h0014_800c);
		@(posedge clock);
		rd(`USCF_A_STAT); chk(v[23:16], 0);
		chk(tx_ready, 0);
		wr(`USCF_A_CFG0, 32'h0010_800c);
		i_uscf_remote.clear_send_n <= 1'b1;
		push(8'h81);
		i_uscf_remote.grab(10, b);
		chk(b, 12'h302);
		// Break and soft modem lines plain, then break and ready line inverted
		wr(`USCF_A_CFG0, 32'h0000_01c0);
		@(posedge clock);
		chk(ser_tx, 0);
		chk({rts_n, dtr_n}, 0);
		wr(`USCF_A_CFG0, 32'h0140_01c0);
		@(posedge clock);
		chk({ser_tx, dtr_n}, 3);
		tally_and_finish;
	end
endmodule // uscf_top_tb_top
